// *** rtl/psc_config_core.sv ***
`timescale 1ns/1ps

module psc_config_core #(
  parameter int PD_ENTRY_NS = 1000
)(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       csN,
  input  wire logic       busClk,
  input  wire logic       resetPinN,
  input  wire logic [7:0] dqIn,
  output logic      [7:0] dqOut,
  output logic            dqOe,
  input  wire logic       strobeMaskIn,
  output logic            strobeMaskOut,
  output logic            strobeMaskOe,
  input  wire logic       refreshPending,
  output logic      [3:0] latencyClocks,
  output logic            fixedLatency,
  output logic      [2:0] driveStrength,
  output logic            deepSleep,
  output logic            retentionSleep,
  output logic            singleEndedClk,
  output logic      [2:0] refreshRegion,
  output logic            refreshEnable
);

  // ****************************************************
  // Timing
  // ****************************************************
  // Entry time is a maximum, so the cycle count rounds down
  localparam int PD_CYC_RAW = PD_ENTRY_NS / psc_pkg::CLK_PERIOD_NS;
  localparam int PD_CYC     = (PD_CYC_RAW < 1) ? 1 : PD_CYC_RAW;
  localparam int PD_W       = $clog2(PD_CYC + 1);

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic [10:0] syncBus;

  psc_sync #(
    .WIDTH     (11),
    .RESET_VAL (11'h500)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .din   ({csN, busClk, resetPinN, dqIn}),
    .dout  (syncBus)
  );

  wire       csS    = syncBus[10];
  wire       ckS    = syncBus[9];
  wire       rstPinS = syncBus[8];
  wire [7:0] dqS    = syncBus[7:0];

  // ****************************************************
  // State
  // ****************************************************
  psc_pkg::psc_state_t state_r;
  psc_pkg::psc_state_t state_nxt;
  logic              ckPrev_r;
  logic              csPrev_r;
  logic [2:0]        byteCnt_r;
  logic [47:0]       caReg_r;
  logic              extra_r;
  logic              regSel_r;
  logic [4:0]        latCnt_r;
  logic [7:0]        wrHi_r;
  logic              pdPend_r;
  logic [PD_W-1:0]   pdCnt_r;
  // Register fields
  logic              awake_r;
  logic [2:0]        drive_r;
  logic [3:0]        lat_r;
  logic              fixed_r;
  logic [2:0]        burst_r;
  logic              clkSel_r;
  logic              sleep_r;
  logic [2:0]        region_r;
  // Pin and status outputs
  logic [7:0]        dqOut_r;
  logic              dqOe_r;
  logic              strobeOut_r;
  logic              strobeOe_r;
  logic              deepSleep_r;
  logic              retention_r;
  logic              refreshEn_r;

  // ****************************************************
  // Edge and event decode
  // ****************************************************
  wire ckRise   = ckS & ~ckPrev_r;
  wire ckFall   = ~ckS & ckPrev_r;
  wire ckEdge   = ckRise | ckFall;
  wire csFall   = ~csS & csPrev_r;
  wire csRise   = csS & ~csPrev_r;
  wire pinReset = ~rstPinS;

  wire [47:0] caNext  = {caReg_r[39:0], dqS};
  wire        caDone  = (state_r == psc_pkg::ST_CA) && ckEdge &&
                        (byteCnt_r == 3'(psc_pkg::CA_BYTES - 1));
  wire        caRead  = caNext[psc_pkg::CA_RW_BIT];
  wire        caReg   = caNext[psc_pkg::CA_SPACE_BIT];
  wire        caRegRd = caReg & caRead;
  wire        caRegWr = caReg & ~caRead;

  // Latency per period; codes outside the supported range fall back to the maximum
  wire        latOk   = (lat_r >= psc_pkg::LAT_MIN) && (lat_r <= psc_pkg::LAT_MAX);
  wire [3:0]  latEff  = latOk ? lat_r : psc_pkg::LAT_MAX;
  // Two latency periods when fixed mode or refresh asked for more
  wire [4:0]  latTotal = extra_r ? {latEff, 1'b0} : {1'b0, latEff};
  wire        latLast  = ckRise && (latCnt_r == (latTotal - 5'h01));

  // Register write commits on the second data edge, never held off by refresh
  wire        wrCommit = (state_r == psc_pkg::ST_WR) && ckFall;
  wire [15:0] wrWord   = {wrHi_r, dqS};
  wire        wrPrim   = wrCommit && (regSel_r == psc_pkg::REG_IDX_PRIMARY);
  wire        wrRefr   = wrCommit && (regSel_r == psc_pkg::REG_IDX_REFRESH);

  // Deep power-down waits for the bus to go quiet
  wire deepEnter = pdPend_r && (pdCnt_r == '0) && csS &&
                   (state_r == psc_pkg::ST_IDLE);
  wire sleepWake = csFall && sleep_r && (state_r == psc_pkg::ST_IDLE);
  wire startTx   = csFall && (state_r == psc_pkg::ST_IDLE) && !sleep_r;

  // Readback words; reserved bits read as fixed ones
  wire [15:0] cr0Word = {awake_r, drive_r, psc_pkg::CR0_RSVD_VAL, lat_r, fixed_r, burst_r};
  wire [15:0] cr1Word = {psc_pkg::CR1_RSVD_VAL, clkSel_r, sleep_r, region_r,
                         psc_pkg::CR1_INTERVAL};
  wire [15:0] rdWord  = (regSel_r == psc_pkg::REG_IDX_REFRESH) ? cr1Word : cr0Word;

  // ****************************************************
  // Transaction sequencer
  // ****************************************************
  // Next state; reset pin overrides all, then deep power-down entry, then chip select release
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      psc_pkg::ST_IDLE: begin
        if (csFall) state_nxt = sleep_r ? psc_pkg::ST_SKIP : psc_pkg::ST_CA;
      end
      psc_pkg::ST_CA: begin
        if (caDone) begin
          if (caRegWr) state_nxt = psc_pkg::ST_WR;
          else if (caRegRd) state_nxt = psc_pkg::ST_LAT;
          else state_nxt = psc_pkg::ST_SKIP;
        end
      end
      psc_pkg::ST_WR: begin
        if (ckFall) state_nxt = psc_pkg::ST_SKIP;
      end
      psc_pkg::ST_LAT: begin
        if (latLast) state_nxt = psc_pkg::ST_RD;
      end
      psc_pkg::ST_RD:   state_nxt = psc_pkg::ST_RD;
      psc_pkg::ST_SKIP: state_nxt = psc_pkg::ST_SKIP;
      psc_pkg::ST_DEEP: begin
        // Only chip select is watched here; the reset pin override below also ends this state
        if (csRise) state_nxt = psc_pkg::ST_IDLE;
      end
      default: state_nxt = psc_pkg::ST_IDLE;
    endcase
    if (csRise && state_r != psc_pkg::ST_DEEP) state_nxt = psc_pkg::ST_IDLE;
    if (deepEnter) state_nxt = psc_pkg::ST_DEEP;
    if (pinReset) state_nxt = psc_pkg::ST_IDLE;
  end

  // State and edge history
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r  <= psc_pkg::ST_IDLE;
      ckPrev_r <= 1'h0;
      csPrev_r <= 1'h1;
    end else begin
      state_r  <= state_nxt;
      ckPrev_r <= ckS;
      csPrev_r <= csS;
    end
  end

  // Command/address shift, byte and latency counters
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      byteCnt_r <= 3'h0;
      caReg_r   <= 48'h0000_0000_0000;
      latCnt_r  <= 5'h00;
      regSel_r  <= 1'h0;
      wrHi_r    <= 8'h00;
    end else begin
      if (startTx) byteCnt_r <= 3'h0;
      else if (state_r == psc_pkg::ST_CA && ckEdge) byteCnt_r <= byteCnt_r + 3'h1;
      if (state_r == psc_pkg::ST_CA && ckEdge) caReg_r <= caNext;
      if (caDone) latCnt_r <= 5'h00;
      else if (state_r == psc_pkg::ST_LAT && ckRise) latCnt_r <= latCnt_r + 5'h01;
      if (caDone) regSel_r <= caNext[psc_pkg::CA_REGSEL_BIT];
      if (state_r == psc_pkg::ST_WR && ckRise) wrHi_r <= dqS;
    end
  end

  // Latency decision is frozen at transaction start
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      extra_r <= 1'h1;
    end else if (startTx) begin
      extra_r <= fixed_r | refreshPending;
    end
  end

  // ****************************************************
  // Configuration registers
  // ****************************************************
  // Defaults on reset, reset pin and deep power-down entry
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      awake_r  <= psc_pkg::CR0_AWAKE_RST;
      drive_r  <= psc_pkg::CR0_DRIVE_RST;
      lat_r    <= psc_pkg::CR0_LAT_RST;
      fixed_r  <= psc_pkg::CR0_FIXED_RST;
      burst_r  <= psc_pkg::CR0_BURST_RST;
      clkSel_r <= psc_pkg::CR1_CLK_RST;
      sleep_r  <= psc_pkg::CR1_SLEEP_RST;
      region_r <= psc_pkg::CR1_REGION_RST;
    end else if (pinReset || deepEnter) begin
      awake_r  <= psc_pkg::CR0_AWAKE_RST;
      drive_r  <= psc_pkg::CR0_DRIVE_RST;
      lat_r    <= psc_pkg::CR0_LAT_RST;
      fixed_r  <= psc_pkg::CR0_FIXED_RST;
      burst_r  <= psc_pkg::CR0_BURST_RST;
      clkSel_r <= psc_pkg::CR1_CLK_RST;
      sleep_r  <= psc_pkg::CR1_SLEEP_RST;
      region_r <= psc_pkg::CR1_REGION_RST;
    end else if (wrPrim) begin
      awake_r  <= wrWord[psc_pkg::CR0_AWAKE_BIT];
      drive_r  <= wrWord[psc_pkg::CR0_DRIVE_LSB +: 3];
      lat_r    <= wrWord[psc_pkg::CR0_LAT_LSB +: 4];
      fixed_r  <= wrWord[psc_pkg::CR0_FIXED_BIT];
      burst_r  <= wrWord[psc_pkg::CR0_BURST_LSB +: 3];
    end else if (wrRefr) begin
      // Reserved and interval bits ignore writes
      clkSel_r <= wrWord[psc_pkg::CR1_CLK_BIT];
      sleep_r  <= wrWord[psc_pkg::CR1_SLEEP_BIT];
      region_r <= wrWord[psc_pkg::CR1_REGION_LSB +: 3];
    end else if (sleepWake) begin
      sleep_r  <= 1'h0;
    end
  end

  // Deep power-down entry timer, armed by a cleared awake bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pdPend_r <= 1'h0;
      pdCnt_r  <= '0;
    end else if (pinReset || deepEnter) begin
      pdPend_r <= 1'h0;
      pdCnt_r  <= '0;
    end else if (wrPrim && !wrWord[psc_pkg::CR0_AWAKE_BIT]) begin
      pdPend_r <= 1'h1;
      pdCnt_r  <= PD_W'(PD_CYC - 1);
    end else if (pdPend_r && pdCnt_r != '0) begin
      pdCnt_r  <= pdCnt_r - 1'b1;
    end
  end

  // ****************************************************
  // Bus pins
  // ****************************************************
  // Strobe driven through CA; released for zero-latency writes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strobeOut_r <= 1'h0;
      strobeOe_r  <= 1'h0;
      dqOut_r     <= 8'h00;
      dqOe_r      <= 1'h0;
    end else if (pinReset || csRise || state_r == psc_pkg::ST_DEEP) begin
      strobeOut_r <= 1'h0;
      strobeOe_r  <= 1'h0;
      dqOut_r     <= 8'h00;
      dqOe_r      <= 1'h0;
    end else if (startTx) begin
      strobeOut_r <= fixed_r | refreshPending;
      strobeOe_r  <= 1'h1;
    end else if (caDone) begin
      strobeOut_r <= 1'h0;
      strobeOe_r  <= caRegRd;
    end else if ((state_r == psc_pkg::ST_LAT && latLast) ||
                 (state_r == psc_pkg::ST_RD && ckRise)) begin
      strobeOut_r <= 1'h1;
      dqOut_r     <= rdWord[15:8];
      dqOe_r      <= 1'h1;
    end else if (state_r == psc_pkg::ST_RD && ckFall) begin
      strobeOut_r <= 1'h0;
      dqOut_r     <= rdWord[7:0];
    end
  end

  // Power state outputs; refresh is held off by reset and deep sleep
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      deepSleep_r <= 1'h0;
      retention_r <= 1'h0;
      refreshEn_r <= 1'h0;
    end else begin
      deepSleep_r <= (state_nxt == psc_pkg::ST_DEEP);
      retention_r <= sleep_r && csS && (state_r == psc_pkg::ST_IDLE);
      refreshEn_r <= !pinReset && (state_nxt != psc_pkg::ST_DEEP);
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign dqOut          = dqOut_r;
  assign dqOe           = dqOe_r;
  assign strobeMaskOut  = strobeOut_r;
  assign strobeMaskOe   = strobeOe_r;
  assign latencyClocks  = lat_r;
  assign fixedLatency   = fixed_r;
  assign driveStrength  = drive_r;
  assign deepSleep      = deepSleep_r;
  assign retentionSleep = retention_r;
  assign singleEndedClk = clkSel_r;
  assign refreshRegion  = region_r;
  assign refreshEnable  = refreshEn_r;

  // Strobe input is only meaningful for array write masking, not handled here
  wire unusedStrobeIn = strobeMaskIn;

endmodule : psc_config_core

// *** rtl/psc_pkg.sv ***
package psc_pkg;

  // ****************************************************
  // Command/address phase layout
  // ****************************************************
  localparam int CA_BYTES      = 6;
  localparam int CA_RW_BIT     = 47;  // 1 = read
  localparam int CA_SPACE_BIT  = 46;  // 1 = register space
  localparam int CA_REGSEL_BIT = 0;   // 0 = primary, 1 = refresh/sleep/clock
  localparam logic REG_IDX_PRIMARY = 1'h0;
  localparam logic REG_IDX_REFRESH = 1'h1;

  // ****************************************************
  // primary_config_reg fields and reset values
  // ****************************************************
  localparam int CR0_AWAKE_BIT = 15;
  localparam int CR0_DRIVE_LSB = 12;
  localparam int CR0_RSVD_LSB  = 8;
  localparam int CR0_LAT_LSB   = 4;
  localparam int CR0_FIXED_BIT = 3;
  localparam int CR0_BURST_LSB = 0;
  localparam logic       CR0_AWAKE_RST = 1'h1;
  localparam logic [2:0] CR0_DRIVE_RST = 3'h0;
  localparam logic [3:0] CR0_RSVD_VAL  = 4'hF;
  localparam logic [3:0] CR0_LAT_RST   = 4'h7;
  localparam logic       CR0_FIXED_RST = 1'h1;
  localparam logic [2:0] CR0_BURST_RST = 3'h7;

  // ****************************************************
  // refresh_sleep_clock_config fields and reset values
  // ****************************************************
  localparam int CR1_RSVD_LSB   = 7;
  localparam int CR1_CLK_BIT    = 6;
  localparam int CR1_SLEEP_BIT  = 5;
  localparam int CR1_REGION_LSB = 2;
  localparam logic [8:0] CR1_RSVD_VAL   = 9'h1FF;
  localparam logic       CR1_CLK_RST    = 1'h1;
  localparam logic       CR1_SLEEP_RST  = 1'h0;
  localparam logic [2:0] CR1_REGION_RST = 3'h0;
  localparam logic [1:0] CR1_INTERVAL   = 2'h1;  // 4 us select-low limit

  // ****************************************************
  // Latency and timing
  // ****************************************************
  localparam logic [3:0] LAT_MIN       = 4'h3;
  localparam logic [3:0] LAT_MAX       = 4'h7;
  localparam int         CLK_PERIOD_NS = 10;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CA   = 3'b001,
    ST_WR   = 3'b010,
    ST_LAT  = 3'b011,
    ST_RD   = 3'b100,
    ST_SKIP = 3'b101,
    ST_DEEP = 3'b110
  } psc_state_t;

endpackage : psc_pkg

// *** rtl/psc_sync.sv ***
`timescale 1ns/1ps

// ****************************************************
// Two-stage synchroniser for pin inputs
// ****************************************************
module psc_sync #(
  parameter int                 WIDTH     = 1,
  parameter logic [WIDTH-1:0]   RESET_VAL = '0
)(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] hold_r;

  // First stage feeds only the second
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r <= RESET_VAL;
      hold_r <= RESET_VAL;
    end else begin
      meta_r <= din;
      hold_r <= meta_r;
    end
  end

  assign dout = hold_r;

endmodule : psc_sync

// *** verif/psc_config_core_props.sv ***
`timescale 1ns/1ps

// ****************************************************
// Port checker for the configuration core
// ****************************************************
module psc_config_core_props #(
  parameter int PD_ENTRY_NS = 1000
)(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       csN,
  input  wire logic       resetPinN,
  input  wire logic       dqOe,
  input  wire logic       strobeMaskOut,
  input  wire logic       strobeMaskOe,
  input  wire logic       refreshPending,
  input  wire logic [3:0] latencyClocks,
  input  wire logic       fixedLatency,
  input  wire logic [2:0] driveStrength,
  input  wire logic       deepSleep,
  input  wire logic       retentionSleep,
  input  wire logic       singleEndedClk,
  input  wire logic [2:0] refreshRegion,
  input  wire logic       refreshEnable
);
  // One domain only, so clock and disable are given once
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (reset);

  // Default field values, shared by reset release and power-down entry
  sequence s_dflt;
    latencyClocks == 4'h7 && fixedLatency && driveStrength == 3'h0 &&
      singleEndedClk && refreshRegion == 3'h0;
  endsequence

  property p_reset_dflt;
    $fell(reset) |-> s_dflt ##0 (!retentionSleep && !deepSleep);
  endproperty
  a_reset_dflt: assert property (p_reset_dflt)
    else $error("fields not at defaults after reset");

  property p_deep_dflt;
    $rose(deepSleep) |-> ##[0:1] s_dflt;
  endproperty
  a_deep_dflt: assert property (p_deep_dflt)
    else $error("fields kept through deep power-down");

  property p_strobe_ca;
    $rose(strobeMaskOe) |-> strobeMaskOut == ($past(fixedLatency) | $past(refreshPending));
  endproperty
  a_strobe_ca: assert property (p_strobe_ca)
    else $error("strobe level in command phase wrong");

  property p_pin_reset;
    (!resetPinN) [*5] |-> !refreshEnable && !retentionSleep && !deepSleep;
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("reset pin did not end sleep or stop refresh");

  property p_sleep_wake;
    $fell(csN) && retentionSleep |-> ##[1:5] !retentionSleep;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("select low did not wake from retention sleep");

  property p_deep_entry;
    $rose(deepSleep) |-> csN;
  endproperty
  a_deep_entry: assert property (p_deep_entry)
    else $error("deep power-down entered with select low");

  property p_deep_hold;
    (deepSleep && !csN && resetPinN) [*4] |=> deepSleep;
  endproperty
  a_deep_hold: assert property (p_deep_hold)
    else $error("deep power-down left without select rise");

  property p_deep_quiet;
    deepSleep |-> !dqOe && !strobeMaskOe;
  endproperty
  a_deep_quiet: assert property (p_deep_quiet)
    else $error("pins driven in deep power-down");

  property p_deep_refr;
    deepSleep |-> !refreshEnable;
  endproperty
  a_deep_refr: assert property (p_deep_refr)
    else $error("refresh running in deep power-down");

  property p_rd_hi;
    $rose(dqOe) |-> strobeMaskOe && strobeMaskOut;
  endproperty
  a_rd_hi: assert property (p_rd_hi)
    else $error("first read byte not marked by strobe");

  // Main scenarios reached
  c_deep: cover property ($rose(deepSleep));
  c_wake: cover property ($fell(retentionSleep) && resetPinN);
  c_pend: cover property ($rose(strobeMaskOe) && strobeMaskOut && !fixedLatency);
endmodule : psc_config_core_props

bind psc_config_core psc_config_core_props #(
  .PD_ENTRY_NS (PD_ENTRY_NS)
) u_props (
  .clk            (clk),
  .reset          (reset),
  .csN            (csN),
  .resetPinN      (resetPinN),
  .dqOe           (dqOe),
  .strobeMaskOut  (strobeMaskOut),
  .strobeMaskOe   (strobeMaskOe),
  .refreshPending (refreshPending),
  .latencyClocks  (latencyClocks),
  .fixedLatency   (fixedLatency),
  .driveStrength  (driveStrength),
  .deepSleep      (deepSleep),
  .retentionSleep (retentionSleep),
  .singleEndedClk (singleEndedClk),
  .refreshRegion  (refreshRegion),
  .refreshEnable  (refreshEnable)
);

// *** verif/psc_config_core_test.sv ***
`timescale 1ns/1ps

// ****************************************************
// Self-checking bench for the configuration core
// ****************************************************
module psc_config_core_test;
  logic        clk;
  logic        reset;
  logic        resetPinN;
  logic        refreshPending;
  logic        csN;
  logic        busClk;
  wire  [7:0]  dqIn;
  wire         strobeMaskIn;
  logic [7:0]  dqOut;
  logic        dqOe;
  logic        strobeMaskOut;
  logic        strobeMaskOe;
  logic [3:0]  latencyClocks;
  logic        fixedLatency;
  logic [2:0]  driveStrength;
  logic        deepSleep;
  logic        retentionSleep;
  logic        singleEndedClk;
  logic [2:0]  refreshRegion;
  logic        refreshEnable;
  logic [15:0] rd;
  logic        strb;
  int          lat;
  int          eff;
  int          fails = 0;
  int          checks = 0;

  // Short power-down entry keeps the run brief
  psc_config_core #(
    .PD_ENTRY_NS (50)
  ) dut (
    .clk            (clk),
    .reset          (reset),
    .csN            (csN),
    .busClk         (busClk),
    .resetPinN      (resetPinN),
    .dqIn           (dqIn),
    .dqOut          (dqOut),
    .dqOe           (dqOe),
    .strobeMaskIn   (strobeMaskIn),
    .strobeMaskOut  (strobeMaskOut),
    .strobeMaskOe   (strobeMaskOe),
    .refreshPending (refreshPending),
    .latencyClocks  (latencyClocks),
    .fixedLatency   (fixedLatency),
    .driveStrength  (driveStrength),
    .deepSleep      (deepSleep),
    .retentionSleep (retentionSleep),
    .singleEndedClk (singleEndedClk),
    .refreshRegion  (refreshRegion),
    .refreshEnable  (refreshEnable)
  );

  // Host side of the bus
  psc_host_model host (
    .csN           (csN),
    .busClk        (busClk),
    .dqIn          (dqIn),
    .strobeMaskIn  (strobeMaskIn),
    .dqOut         (dqOut),
    .dqOe          (dqOe),
    .strobeMaskOut (strobeMaskOut),
    .strobeMaskOe  (strobeMaskOe)
  );

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Compare and count
  task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check16

  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  // Watchdog: the tests need about 65 us, so 400 us means a hang
  initial begin
    #400_000;
    fails++;
    $display("BAD t=%0t watchdog", $time);
    results();
  end

  initial begin
    reset = 1'h1;
    resetPinN = 1'h1;
    refreshPending = 1'h0;
    repeat (6) @(posedge clk);
    #1 reset = 1'h0;
    repeat (4) @(posedge clk);
    // Host pins then move 1 ns after clock edges for the whole run
    #1;
    host.xfer(1'h1, 1'h0, 16'h0000, rd, lat, strb);
    check16(rd, 16'h8F7F, "primary reset");
    check16(16'(lat), 16'h000E, "fixed latency");
    check16(16'(strb), 16'h0001, "fixed strobe");
    host.xfer(1'h1, 1'h1, 16'h0000, rd, lat, strb);
    check16(rd, 16'hFFC1, "second reset");
    $display("test defaults done");
    // Latency codes 2 to 7, the out-of-range 2 too, with and without refresh
    for (int l = 2; l <= 7; l++) begin
      host.xfer(1'h0, 1'h0, {4'hD, 4'hF, 4'(l), 4'h7}, rd, lat, strb);
      check16(16'(latencyClocks), 16'(l), "lat field");
      check16(16'(driveStrength), 16'h0005, "drive field");
      check16(16'(fixedLatency), 16'h0000, "fixed field");
      @(posedge clk);
      #1 refreshPending = l[0];
      host.xfer(1'h1, 1'h0, 16'h0000, rd, lat, strb);
      eff = (l < 3) ? 7 : l;
      check16(rd, {4'hD, 4'hF, 4'(l), 4'h7}, "primary read");
      check16(16'(lat), 16'(l[0] ? 2 * eff : eff), "latency");
      check16(16'(strb), 16'(l[0]), "refresh strobe");
    end
    $display("test latency done");
    // Refresh regions and clock type; interval stays read-only
    for (int r = 0; r < 8; r++) begin
      host.xfer(1'h0, 1'h1, {9'h1FF, r[0], 1'h0, 3'(r), 2'h0}, rd, lat, strb);
      check16(16'(refreshRegion), 16'(r), "region");
      check16(16'(singleEndedClk), 16'(r[0]), "clock type");
      host.xfer(1'h1, 1'h1, 16'h0000, rd, lat, strb);
      check16(rd, {9'h1FF, r[0], 1'h0, 3'(r), 2'h1}, "second read");
    end
    $display("test regions done");
    // Retention sleep: wake by select, then by the reset pin
    host.xfer(1'h0, 1'h1, 16'hFFE1, rd, lat, strb);
    check16(16'(retentionSleep), 16'h0001, "sleep on");
    host.pulse();
    check16(16'(retentionSleep), 16'h0000, "sleep woken");
    host.xfer(1'h1, 1'h1, 16'h0000, rd, lat, strb);
    check16(rd, 16'hFFC1, "sleep bit cleared");
    host.xfer(1'h0, 1'h1, 16'hFFE1, rd, lat, strb);
    @(posedge clk);
    #1 resetPinN = 1'h0;
    repeat (6) @(posedge clk);
    #1 check16(16'({refreshEnable, retentionSleep}), 16'h0000, "pin reset");
    resetPinN = 1'h1;
    repeat (6) @(posedge clk);
    #1 check16(16'(refreshEnable), 16'h0001, "refresh back");
    $display("test sleep done");
    // Deep power-down entry, exit and loss of settings
    host.xfer(1'h0, 1'h0, 16'h0F3F, rd, lat, strb);
    repeat (20) @(posedge clk);
    #1 check16(16'({deepSleep, refreshEnable}), 16'h0002, "deep entry");
    host.pulse();
    check16(16'(deepSleep), 16'h0000, "deep exit");
    host.xfer(1'h1, 1'h0, 16'h0000, rd, lat, strb);
    check16(rd, 16'h8F7F, "defaults after deep");
    $display("test deep done");
    results();
  end
endmodule : psc_config_core_test

// *** verif/psc_host_model.sv ***
`timescale 1ns/1ps

// ****************************************************
// Host controller model: select, bus clock, data bytes
// ****************************************************
module psc_host_model (
  output logic            csN,
  output logic            busClk,
  output wire logic [7:0] dqIn,
  output wire logic       strobeMaskIn,
  input  wire logic [7:0] dqOut,
  input  wire logic       dqOe,
  input  wire logic       strobeMaskOut,
  input  wire logic       strobeMaskOe
);
  logic [7:0] hostDq;
  logic       hostDrv;

  // Released data lines show the inverse, so stale bytes cannot pass
  assign dqIn = dqOe ? dqOut : (hostDrv ? hostDq : ~hostDq);
  // Host never drives the strobe; an undriven line flips
  assign strobeMaskIn = strobeMaskOe ? strobeMaskOut : ~strobeMaskOut;

  // Bus clock stands low outside frames
  initial begin
    csN = 1'h1;
    busClk = 1'h0;
    hostDq = 8'h00;
    hostDrv = 1'h0;
  end

  // One edge with the byte centred: 40 ns either side
  task automatic edgeOut(input logic [7:0] b);
    hostDq = b;
    hostDrv = 1'h1;
    #40;
    busClk = ~busClk;
    #40;
  endtask : edgeOut

  // Register transfer; frames stay below the select-low limit
  task automatic xfer(input logic rd, input logic sel, input logic [15:0] wd,
                      output logic [15:0] rdat, output int lat, output logic strb);
    logic [47:0] ca;
    ca = {rd, 1'h1, 45'h0, sel};
    rdat = 'x;
    lat = 0;
    csN = 1'h0;
    #80;
    strb = (strobeMaskOe === 1'h1) ? strobeMaskOut : 1'hx;
    for (int i = 5; i >= 0; i--) edgeOut(ca[i*8 +: 8]);
    if (!rd) begin
      edgeOut(wd[15:8]);
      edgeOut(wd[7:0]);
    end else begin
      hostDrv = 1'h0;
      for (int k = 1; k <= 40 && lat == 0; k++) begin
        busClk = 1'h1;
        #80;
        if (dqOe === 1'h1) begin
          lat = k;
          rdat[15:8] = dqOut;
        end
        busClk = 1'h0;
        #80;
        if (lat != 0) rdat[7:0] = dqOut;
      end
    end
    hostDrv = 1'h0;
    csN = 1'h1;
    #200;
  endtask : xfer

  // Bare select pulse, used to wake the device
  task automatic pulse();
    csN = 1'h0;
    #100;
    csN = 1'h1;
    #200;
  endtask : pulse
endmodule : psc_host_model
